/* common/pmx_cfg.svh */
// Constants of the processor mode pin function multiplexer
// Assumes inclusion by bare name from any design or bench file
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH

`define PMX_MODE_SINGLE   2'h0
`define PMX_MODE_EXPAND   2'h1
`define PMX_MODE_MICRO    2'h2
`define PMX_MODE_LSB      0
`define PMX_MODE_MSB      1
`define PMX_CS_SEL_BIT    7
`define PMX_MODE_RESET    2'h0
`define PMX_SEL_RESET     5'h00
`define PMX_CSU_RESET     3'h0
`define PMX_PORT2_WIDTH   8
`define PMX_CSU_WIDTH     3

`endif

/* common/pmx_pkg.sv */
// Types of the processor mode pin function multiplexer
// Assumes pmx_cfg.svh is reachable on the include path
`include "pmx_cfg.svh"

package pmx_pkg;

  typedef enum logic [1:0] {
    PMX_SINGLE,
    PMX_EXPAND,
    PMX_MICRO,
    PMX_RESERVED
  } pmx_mode_t;

  // One pin seen from the pad: output and enable
  typedef struct packed {
    logic o;
    logic oe;
  } pmx_drive_t;

  // Bus side signals produced by the bus interface unit
  typedef struct packed {
    logic [7:0] odd_data_out;
    logic       odd_data_oe;
    logic       read_n;
    logic       low_byte_write_n;
    logic       high_byte_write_n;
    logic       addr_latch;
    logic       sys_clk_out;
    logic       bus_grant_ack_n;
    logic       chip_select_first_n;
    logic [2:0] chip_select_upper_n;
  } pmx_bus_t;

  // Per-pin select bits swapping the mode default
  typedef struct packed {
    logic wait_sel;
    logic latch_sel;
    logic clk_sel;
    logic ack_sel;
    logic req_sel;
  } pmx_sel_t;

endpackage

/* hdl/pmx_pin_cell.sv */
// One multipurpose pin: registered choice between port and bus function
// Assumes synchronous inputs on clk
`timescale 1ns/10ps

module pmx_pin_cell (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic bus_use,
  input  wire logic bus_o,
  input  wire logic bus_oe,
  input  wire logic port_o,
  input  wire logic port_oe,
  output logic      pin_o,
  output logic      pin_oe
);

  // ************************************************************
  // Output register
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b0;
    end else if (bus_use) begin
      // Port registers ignored while bus owns the pin
      pin_o  <= bus_o;
      pin_oe <= bus_oe;
    end else begin
      pin_o  <= port_o;
      pin_oe <= port_oe;
    end
  end

endmodule

/* hdl/pmx_pin_mux.sv */
// Processor mode pin function multiplexer: ports two, three, four, nine
// Assumes mode and select bits come from registers elsewhere, all on clk
`timescale 1ns/10ps
`include "pmx_cfg.svh"

// Operation
// - 16-bit external bus: port two odd data
// - 8-bit external bus: port two stays I/O
// - Wait input default micro, selectable in expansion
// - Port three bit one is read strobe
// - Low write strobe: even or every write
// - High write strobe only with 16-bit bus
// - Address latch default micro, selectable expansion
// - Clock output default micro, selectable otherwise
// - Grant ack default micro, selectable expansion
// - Hold request input default micro, selectable expansion
// - First chip select default micro, selectable expansion
// - Upper chip selects follow their select bits in micro and expansion modes
// - Mode from mode register bits one, zero
// - Select bits invert each pin's mode default in micro and expansion modes
// - Control bit 7 enables first chip select

module pmx_pin_mux (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [7:0]          mode_reg_zero,
  input  wire pmx_pkg::pmx_sel_t   pin_sel,
  input  wire logic [7:0]          cs_first_ctrl,
  input  wire logic [2:0]          cs_upper_sel,
  input  wire logic                bus_width_16,
  input  wire pmx_pkg::pmx_bus_t   bus_in,
  input  wire logic [7:0]          port_two_out,
  input  wire logic [7:0]          port_two_dir,
  input  wire logic [3:0]          port_three_out,
  input  wire logic [3:0]          port_three_dir,
  input  wire logic [3:0]          port_four_out,
  input  wire logic [3:0]          port_four_dir,
  input  wire logic [3:0]          port_nine_out,
  input  wire logic [3:0]          port_nine_dir,
  input  wire logic [7:0]          port_two_pins_i,
  input  wire logic                port_three_bit_zero_i,
  input  wire logic                port_four_bit_three_i,
  output logic [7:0]               port_two_pins_o,
  output logic [7:0]               port_two_pins_oe,
  output logic [3:0]               port_three_o,
  output logic [3:0]               port_three_oe,
  output logic [3:0]               port_four_o,
  output logic [3:0]               port_four_oe,
  output logic [3:0]               port_nine_o,
  output logic [3:0]               port_nine_oe,
  output logic [7:0]               odd_data_in_reg,
  output logic                     wait_n_reg,
  output logic                     bus_hold_req_n_reg,
  output pmx_pkg::pmx_mode_t       mode_reg
);

  // ************************************************************
  // Mode decode
  // ************************************************************
  logic             ext_mode;
  logic             micro_mode;
  logic             expand_mode;
  logic [15:0]      use_bus;
  logic [15:0]      bus_o;
  logic [15:0]      bus_oe;
  logic [15:0]      port_o;
  logic [15:0]      port_oe;
  logic [15:0]      pin_o;
  logic [15:0]      pin_oe;

  // Default in micro, inverted by the select bit; expansion only selectable
  function automatic logic sel_use(input logic micro, input logic expand, input logic sel);
    sel_use = micro ? ~sel : (expand & sel);
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_reg <= pmx_pkg::PMX_SINGLE;
    end else begin
      // Reserved code 11 falls back to single-chip
      case (mode_reg_zero[`PMX_MODE_MSB:`PMX_MODE_LSB])
        `PMX_MODE_EXPAND: mode_reg <= pmx_pkg::PMX_EXPAND;
        `PMX_MODE_MICRO:  mode_reg <= pmx_pkg::PMX_MICRO;
        default:          mode_reg <= pmx_pkg::PMX_SINGLE;
      endcase
    end
  end

  assign micro_mode  = (mode_reg == pmx_pkg::PMX_MICRO);
  assign expand_mode = (mode_reg == pmx_pkg::PMX_EXPAND);
  assign ext_mode    = micro_mode | expand_mode;

  // ************************************************************
  // Function selection per pin
  // ************************************************************
  always_comb begin
    use_bus[7:0] = {8{ext_mode & bus_width_16}};
    use_bus[8]   = sel_use(micro_mode, expand_mode, pin_sel.wait_sel);
    use_bus[9]   = ext_mode;
    use_bus[10]  = ext_mode;
    use_bus[11]  = ext_mode & bus_width_16;
    use_bus[12]  = sel_use(micro_mode, expand_mode, pin_sel.latch_sel);
    // Clock output is selectable even in single-chip mode
    use_bus[13]  = micro_mode ? ~pin_sel.clk_sel : pin_sel.clk_sel;
    use_bus[14]  = sel_use(micro_mode, expand_mode, pin_sel.ack_sel);
    use_bus[15]  = sel_use(micro_mode, expand_mode, pin_sel.req_sel);
  end

  always_comb begin
    bus_o  = {bus_in.bus_grant_ack_n, bus_in.bus_grant_ack_n, bus_in.sys_clk_out,
              bus_in.addr_latch, bus_in.high_byte_write_n, bus_in.low_byte_write_n,
              bus_in.read_n, 1'b1, bus_in.odd_data_out};
    bus_o[15] = 1'b1;
    // Wait and hold request are inputs: pad released
    bus_oe = {1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
              {8{bus_in.odd_data_oe}}};
    port_o  = {port_four_out, port_three_out, port_two_out};
    port_oe = {port_four_dir, port_three_dir, port_two_dir};
  end

  // ************************************************************
  // Pin cells, registered outputs
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_cell
      pmx_pin_cell u_cell (
        .clk     (clk),
        .rst_n   (rst_n),
        .bus_use (use_bus[gi]),
        .bus_o   (bus_o[gi]),
        .bus_oe  (bus_oe[gi]),
        .port_o  (port_o[gi]),
        .port_oe (port_oe[gi]),
        .pin_o   (pin_o[gi]),
        .pin_oe  (pin_oe[gi])
      );
    end
  endgenerate

  assign port_two_pins_o  = pin_o[7:0];
  assign port_two_pins_oe = pin_oe[7:0];
  assign port_three_o     = pin_o[11:8];
  assign port_three_oe    = pin_oe[11:8];
  assign port_four_o      = pin_o[15:12];
  assign port_four_oe     = pin_oe[15:12];

  // ************************************************************
  // Port nine chip selects
  // ************************************************************
  logic first_cs_use;
  assign first_cs_use = micro_mode | (expand_mode & cs_first_ctrl[`PMX_CS_SEL_BIT]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_nine_o  <= 4'h0;
      port_nine_oe <= 4'h0;
    end else begin
      if (first_cs_use) begin
        port_nine_o[0]  <= bus_in.chip_select_first_n;
        port_nine_oe[0] <= 1'b1;
      end else begin
        port_nine_o[0]  <= port_nine_out[0];
        port_nine_oe[0] <= port_nine_dir[0];
      end
      for (int i = 0; i < `PMX_CSU_WIDTH; i++) begin
        if (ext_mode && cs_upper_sel[i]) begin
          port_nine_o[i+1]  <= bus_in.chip_select_upper_n[i];
          port_nine_oe[i+1] <= 1'b1;
        end else begin
          port_nine_o[i+1]  <= port_nine_out[i+1];
          port_nine_oe[i+1] <= port_nine_dir[i+1];
        end
      end
    end
  end

  // ************************************************************
  // Inputs toward the bus interface unit
  // ************************************************************
  // Inactive levels when the pin is in port use, so the bus never stalls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      odd_data_in_reg    <= 8'h00;
      wait_n_reg         <= 1'b1;
      bus_hold_req_n_reg <= 1'b1;
    end else begin
      odd_data_in_reg    <= use_bus[0] ? port_two_pins_i : 8'h00;
      wait_n_reg         <= use_bus[8] ? port_three_bit_zero_i : 1'b1;
      bus_hold_req_n_reg <= use_bus[15] ? port_four_bit_three_i : 1'b1;
    end
  end

endmodule

/* verif/pmx_pin_mux_props.sv */
// Checker of pin function choice at the mux ports
// Assumes binding to pmx_pin_mux; one clock, sync active-low reset
`timescale 1ns/10ps

module pmx_pin_mux_props (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [7:0]         mode_reg_zero,
  input wire pmx_pkg::pmx_sel_t  pin_sel,
  input wire logic [7:0]         cs_first_ctrl,
  input wire logic [2:0]         cs_upper_sel,
  input wire logic               bus_width_16,
  input wire pmx_pkg::pmx_bus_t  bus_in,
  input wire logic [7:0]         port_two_out,
  input wire logic [7:0]         port_two_dir,
  input wire logic               port_three_bit_zero_i,
  input wire logic [7:0]         port_two_pins_o,
  input wire logic [7:0]         port_two_pins_oe,
  input wire logic [3:0]         port_three_o,
  input wire logic [3:0]         port_three_oe,
  input wire logic [3:0]         port_nine_o,
  input wire logic [3:0]         port_nine_oe,
  input wire logic               wait_n_reg,
  input wire pmx_pkg::pmx_mode_t mode_reg
);
  // ****
  // Pin choice follows the registered mode, so each check looks one edge on
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic micro;
  logic ext;
  assign micro = mode_reg == pmx_pkg::PMX_MICRO;
  assign ext = micro || (mode_reg == pmx_pkg::PMX_EXPAND);

  a_port_two_io: assert property ((!ext || !bus_width_16) |=>
    port_two_pins_o == $past(port_two_out) && port_two_pins_oe == $past(port_two_dir))
    else $error("port two not general I/O");
  a_odd_lane: assert property (ext && bus_width_16 |=>
    port_two_pins_o == $past(bus_in.odd_data_out) && port_two_pins_oe == {8{$past(bus_in.odd_data_oe)}})
    else $error("odd lane wrong");
  a_read_write: assert property (ext |=> (&port_three_oe[2:1]) &&
    port_three_o[2:1] == {$past(bus_in.low_byte_write_n), $past(bus_in.read_n)})
    else $error("read or low write strobe wrong");
  a_high_write: assert property (ext && bus_width_16 |=> port_three_oe[3] &&
    port_three_o[3] == $past(bus_in.high_byte_write_n)) else $error("high write strobe wrong");
  a_wait_input: assert property (ext && (micro != pin_sel.wait_sel) |=>
    !port_three_oe[0] && wait_n_reg == $past(port_three_bit_zero_i)) else $error("wait input wrong");
  a_first_cs: assert property (micro || (ext && cs_first_ctrl[7]) |=>
    port_nine_oe[0] && port_nine_o[0] == $past(bus_in.chip_select_first_n))
    else $error("first chip select wrong");
  a_upper_cs: assert property (ext && cs_upper_sel[2] |=> port_nine_oe[3] &&
    port_nine_o[3] == $past(bus_in.chip_select_upper_n[2])) else $error("upper chip select wrong");
  a_mode_decode: assert property (1'b1 |=> mode_reg ==
    ($past(mode_reg_zero[1:0]) == 2'h3 ? 2'h0 : $past(mode_reg_zero[1:0])))
    else $error("mode decode wrong");
endmodule

/* verif/pmx_bus_partner.sv */
// Model of external memory and bus master beside the multiplexed pins
// Assumes the bench resolves each pad from the multiplexer's enable alone
`timescale 1ns/10ps

module pmx_bus_partner #(
  parameter logic [7:0] READ_DATA = 8'h5A
) (
  input  wire logic       clk,
  input  wire logic       read_n,
  input  wire logic [7:0] lane_oe,
  input  wire logic       slow,
  input  wire logic       hold,
  output logic [7:0]      lane_d = 8'h00,
  output logic            wait_n,
  output logic            hold_req_n
);
  // ****
  // Released lane toggles, so stale data never passes for a read
  // ****
  always @(posedge clk) begin
    if (!read_n && lane_oe == 8'h00) begin
      lane_d <= READ_DATA;
    end else begin
      lane_d <= ~lane_d;
    end
  end
  assign wait_n = !slow;
  assign hold_req_n = !hold;
endmodule

/* verif/tb_pmx_pin_mux.sv */
// Self-checking bench of the pin function multiplexer
// Assumes pmx_pkg compiled first; inputs change on falling edges
`timescale 1ns/10ps

module tb_pmx_pin_mux;
  // ****
  // Signals, pads and partner
  // ****
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] mode_reg_zero, cs_first_ctrl, port_two_out, port_two_dir, port_two_pins_i;
  logic [3:0] port_three_out, port_three_dir, port_four_out, port_four_dir;
  logic [3:0] port_nine_out, port_nine_dir, port_three_o, port_three_oe;
  logic [3:0] port_four_o, port_four_oe, port_nine_o, port_nine_oe;
  logic [7:0] port_two_pins_o, port_two_pins_oe, odd_data_in_reg, lane_d;
  logic [2:0] cs_upper_sel;
  logic bus_width_16, port_three_bit_zero_i, port_four_bit_three_i, slow, hold;
  logic wait_n_reg, bus_hold_req_n_reg, wait_n, hold_req_n;
  pmx_pkg::pmx_sel_t pin_sel;
  pmx_pkg::pmx_bus_t bus_in;
  pmx_pkg::pmx_mode_t mode_reg;
  int fail_count = 0;
  int tests_run = 0;

  pmx_pin_mux dut_u (
    .clk(clk), .rst_n(rst_n), .mode_reg_zero(mode_reg_zero), .pin_sel(pin_sel),
    .cs_first_ctrl(cs_first_ctrl), .cs_upper_sel(cs_upper_sel), .bus_width_16(bus_width_16),
    .bus_in(bus_in), .port_two_out(port_two_out), .port_two_dir(port_two_dir),
    .port_three_out(port_three_out), .port_three_dir(port_three_dir),
    .port_four_out(port_four_out), .port_four_dir(port_four_dir),
    .port_nine_out(port_nine_out), .port_nine_dir(port_nine_dir),
    .port_two_pins_i(port_two_pins_i), .port_three_bit_zero_i(port_three_bit_zero_i),
    .port_four_bit_three_i(port_four_bit_three_i), .port_two_pins_o(port_two_pins_o),
    .port_two_pins_oe(port_two_pins_oe), .port_three_o(port_three_o),
    .port_three_oe(port_three_oe), .port_four_o(port_four_o), .port_four_oe(port_four_oe),
    .port_nine_o(port_nine_o), .port_nine_oe(port_nine_oe),
    .odd_data_in_reg(odd_data_in_reg), .wait_n_reg(wait_n_reg),
    .bus_hold_req_n_reg(bus_hold_req_n_reg), .mode_reg(mode_reg));
  pmx_bus_partner part_u (.clk(clk), .read_n(port_three_o[1]), .lane_oe(port_two_pins_oe),
    .slow(slow), .hold(hold), .lane_d(lane_d), .wait_n(wait_n), .hold_req_n(hold_req_n));
  assign port_two_pins_i = (port_two_pins_oe & port_two_pins_o) | (~port_two_pins_oe & lane_d);
  assign port_three_bit_zero_i = port_three_oe[0] ? port_three_o[0] : wait_n;
  assign port_four_bit_three_i = port_four_oe[3] ? port_four_o[3] : hold_req_n;

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cfg(input logic [1:0] m, input logic w16, input logic [4:0] sel);
    @(negedge clk);
    mode_reg_zero = {6'h3F, m};
    bus_width_16 = w16;
    pin_sel = sel;
    repeat (3) @(negedge clk);
  endtask

  task automatic t_single();
    cfg(2'h0, 1'b1, 5'h00);
    chk({port_two_pins_o, port_two_pins_oe}, 16'h3CC3);
    chk({port_three_o, port_three_oe, port_four_o, port_four_oe}, 16'hA569);
    chk({8'h00, port_nine_o, port_nine_oe}, 16'h00D2);
    chk({14'h0000, wait_n_reg, bus_hold_req_n_reg}, 16'h0003);
    cfg(2'h0, 1'b1, 5'h04);
    chk({8'h00, port_four_o, port_four_oe}, 16'h004B);
    cfg(2'h3, 1'b1, 5'h00);
    chk({14'h0000, mode_reg}, 16'h0000);
    chk({port_two_pins_o, port_two_pins_oe}, 16'h3CC3);
  endtask

  task automatic t_micro();
    cfg(2'h2, 1'b1, 5'h00);
    chk({14'h0000, mode_reg}, 16'h0002);
    chk({port_two_pins_o, port_two_pins_oe}, 16'hA5FF);
    chk({port_three_o & 4'hE, port_three_oe, port_four_o & 4'h7, port_four_oe}, 16'h4E17);
    chk({8'h00, port_nine_o, port_nine_oe}, 16'h00C3);
    chk({14'h0000, wait_n_reg, bus_hold_req_n_reg}, 16'h0000);
    bus_in.odd_data_oe = 1'b0;
    {slow, hold} = 2'h0;
    repeat (3) @(negedge clk);
    chk({8'h00, odd_data_in_reg}, 16'h005A);
    chk({14'h0000, wait_n_reg, bus_hold_req_n_reg}, 16'h0003);
    bus_in.odd_data_oe = 1'b1;
    {slow, hold} = 2'h3;
    cfg(2'h2, 1'b1, 5'h1F);
    chk({port_three_o & 4'hE, port_three_oe, port_four_o & 4'h7, port_four_oe}, 16'h4F69);
    chk({14'h0000, wait_n_reg, bus_hold_req_n_reg}, 16'h0003);
  endtask

  task automatic t_expand();
    cfg(2'h1, 1'b0, 5'h00);
    chk({port_two_pins_o, port_two_pins_oe}, 16'h3CC3);
    chk({port_three_o & 4'hE, port_three_oe, port_four_o & 4'h7, port_four_oe}, 16'hC769);
    chk({8'h00, port_nine_o, port_nine_oe}, 16'h00D2);
    chk({14'h0000, wait_n_reg, bus_hold_req_n_reg}, 16'h0003);
    cs_first_ctrl = 8'h80;
    cs_upper_sel = 3'h7;
    cfg(2'h1, 1'b0, 5'h1F);
    chk({port_three_o & 4'hE, port_three_oe, port_four_o & 4'h7, port_four_oe}, 16'hC617);
    chk({8'h00, port_nine_o, port_nine_oe}, 16'h00AF);
    chk({14'h0000, wait_n_reg, bus_hold_req_n_reg}, 16'h0000);
  endtask

  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    {mode_reg_zero, cs_first_ctrl, cs_upper_sel, bus_width_16, slow, hold} = 22'h000003;
    pin_sel = 5'h00;
    {port_two_out, port_two_dir} = 16'h3CC3;
    {port_three_out, port_three_dir, port_four_out, port_four_dir} = 16'hA569;
    {port_nine_out, port_nine_dir} = 8'hD2;
    bus_in = {8'hA5, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h5};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_single();
    t_micro();
    t_expand();
    test_done();
  end

  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule

bind pmx_pin_mux pmx_pin_mux_props props_u (
  .clk(clk), .rst_n(rst_n), .mode_reg_zero(mode_reg_zero), .pin_sel(pin_sel),
  .cs_first_ctrl(cs_first_ctrl), .cs_upper_sel(cs_upper_sel), .bus_width_16(bus_width_16),
  .bus_in(bus_in), .port_two_out(port_two_out), .port_two_dir(port_two_dir),
  .port_three_bit_zero_i(port_three_bit_zero_i), .port_two_pins_o(port_two_pins_o),
  .port_two_pins_oe(port_two_pins_oe), .port_three_o(port_three_o),
  .port_three_oe(port_three_oe), .port_nine_o(port_nine_o), .port_nine_oe(port_nine_oe),
  .wait_n_reg(wait_n_reg), .mode_reg(mode_reg));
